// >>> src/servo_seq_regs.svh
// register map, field positions, reset values and timing counts of the servo sequencer
// Overview of operation
// R1: profile change applies from next step move
// R2: combined block type 1 forces linear profile
// R3: S-shaped time zero gives linear profile
// R4: out-of-range S-shaped time gives linear profile
// R5: S-time must stay below encoder-dependent limit
// R6: reject operation commands during initialization interval
// R7: ready output only after init, no error
// R8: host asserts servo-on after ready, power settled
// R9: protective functions active 1.5 s after start
// R10: host settles protective input levels beforehand
// R11: t1 ends at alarm time or 30 r/min
// R12: stationary motor at alarm gives zero t1
// R13: alarm clears homing and current position outputs
// R14: S-shaped time held as 16-bit parameter
`ifndef SERVO_SEQ_REGS_SVH
`define SERVO_SEQ_REGS_SVH

`define REG_S_TIME      8'h00
`define REG_ACCEL       8'h04
`define REG_CFG         8'h08
`define REG_BRK_TIME    8'h0C
`define REG_STATUS      8'h10
`define REG_IRQ_STATUS  8'h14
`define REG_IRQ_MASK    8'h18

`define CFG_BLOCK_LSB   0
`define CFG_ENC17_BIT   8
`define CFG_BRKSEQ_LSB  12
`define BRK_STALL_LSB   16

`define S_TIME_RST      16'h0000
`define ACCEL_RST       16'h0064
`define CFG_RST         32'h0000_0000
`define BRK_TIME_RST    32'h0000_0000
`define IRQ_MASK_RST    4'h0

`define IRQ_ALARM       0
`define IRQ_T1_END      1
`define IRQ_REJECT      2
`define IRQ_READY       3
`define IRQ_W           4

`define BLOCK_COMBINED  8'h01
`define STALL_RPM       16'h001E
`define S_LIMIT_2500_X100 32'h00C3_3C78
`define S_LIMIT_17B_X100  32'h09FF_0000

`define CLK_FREQ_HZ     125000000
`define CYC_PER_MS      (`CLK_FREQ_HZ / 1000)
`define INIT_TIME_MS    100
`define PROTECT_TIME_MS 1500

`endif

// >>> src/servo_seq_pkg.sv
// types shared by the servo profile and alarm sequencer
package servo_seq_pkg;
   typedef enum logic [1:0] {BRK_IDLE, BRK_RUN, BRK_HOLD} brake_state_t;

   typedef struct packed {
      logic [15:0] s_time_ms;
      logic [15:0] accel_ms;
      logic [7:0] block_type;
      logic enc_17bit;
   } profile_cfg_t;

   typedef struct packed {
      logic s_setting_ok;
      logic servo_engaged;
      logic homing_done;
      logic s_curve_active;
      logic t1_active;
      logic alarm;
      logic protect_active;
      logic init_done;
   } seq_status_t;
endpackage

// >>> src/s_curve_range_check.sv
// decides whether the S-shaped profile setting is usable for the next move
`include "servo_seq_regs.svh"
module s_curve_range_check (
   input wire servo_seq_pkg::profile_cfg_t cfg,
   output logic s_curve_ok
);
   localparam int PW = 41;
   logic [PW-1:0] lhs;
   logic [PW-1:0] limit;

   // (s+1)*acc*100 < K*100 avoids a divider and keeps the 0.24 fraction exact
   assign lhs = PW'((PW'(cfg.s_time_ms) + PW'(1)) * PW'(cfg.accel_ms) * PW'(100)); // R5
   assign limit = cfg.enc_17bit ? PW'(`S_LIMIT_17B_X100) : PW'(`S_LIMIT_2500_X100); // R5

   always_comb begin
      s_curve_ok = 1'b1;
      if (cfg.block_type == `BLOCK_COMBINED) s_curve_ok = 1'b0; // R2
      if (cfg.s_time_ms == 16'h0000) s_curve_ok = 1'b0; // R3
      // zero ramp time has no meaningful limit, so treat it as linear
      if (cfg.accel_ms == 16'h0000) s_curve_ok = 1'b0; // R4
      if (lhs >= limit) s_curve_ok = 1'b0; // R4
   end
endmodule // s_curve_range_check

// >>> src/servo_profile_and_alarm_sequencer.sv
// servo profile selection, power-on readiness and alarm braking sequencer
//
// Our own choices: register access over AXI4-Lite and the register offsets.
`include "servo_seq_regs.svh"
module servo_profile_and_alarm_sequencer #(
   parameter int MS_CYCLES = `CYC_PER_MS,
   parameter int INIT_MS = `INIT_TIME_MS,
   parameter int PROTECT_MS = `PROTECT_TIME_MS,
   parameter int POS_W = 6
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic servo_on_input,
   input wire logic cw_overtravel_inhibit,
   input wire logic ccw_overtravel_inhibit,
   input wire logic emergency_stop_input,
   input wire logic fault_input,
   input wire logic alarm_clear_input,
   input wire logic [15:0] motor_speed_rpm,
   input wire logic step_start_input,
   input wire logic homing_start_input,
   input wire logic move_done_input,
   input wire logic [POS_W-1:0] done_point_input,
   output logic servo_alarm_output,
   output logic motor_drive_on,
   output logic t1_active,
   output logic cw_drive_inhibit,
   output logic ccw_drive_inhibit,
   output logic move_busy,
   output logic active_s_curve,
   output logic [15:0] active_s_time_ms,
   output logic [15:0] active_accel_ms,
   output logic homing_done,
   output logic [POS_W-1:0] current_position_outputs,
   output logic [3:0] alarm_sequence_param,
   output logic [15:0] stall_brake_time_param,
   output logic irq
);
   generate
      if (MS_CYCLES < 2 || INIT_MS < 1 || PROTECT_MS < INIT_MS || PROTECT_MS > 65535
          || POS_W < 1 || POS_W > 16) begin : g_bad_param
         $error("servo sequencer: unsupported parameter values");
      end
   endgenerate

   localparam int MSW = $clog2(MS_CYCLES);

   function automatic logic reg_mapped(input logic [7:0] a);
      reg_mapped = (a == `REG_S_TIME) || (a == `REG_ACCEL) || (a == `REG_CFG) ||
                   (a == `REG_BRK_TIME) || (a == `REG_STATUS) ||
                   (a == `REG_IRQ_STATUS) || (a == `REG_IRQ_MASK);
   endfunction

   function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] d,
                                              input logic [3:0] s);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) r[8*i +: 8] = d[8*i +: 8];
      end
      apply_strb = r;
   endfunction

   // software-visible settings
   logic [15:0] s_time_r; // R14
   logic [15:0] accel_r;
   logic [7:0] block_type_r;
   logic enc17_r;
   logic [3:0] brk_seq_r;
   logic [15:0] brk_run_r;
   logic [15:0] stall_time_r;
   logic [`IRQ_W-1:0] irq_stat_r;
   logic [`IRQ_W-1:0] irq_mask_r;

   // bus slave state
   logic aw_hold_r;
   logic w_hold_r;
   logic [7:0] aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic wr_fire;

   // sequencing state
   logic [MSW-1:0] ms_cnt_r;
   logic ms_tick;
   logic [15:0] ms_since_r;
   logic init_done_r;
   logic protect_r;
   logic alarm_r;
   logic step_busy_r;
   logic homing_move_r;
   logic [15:0] t1_cnt_r;
   servo_seq_pkg::brake_state_t brk_r;
   servo_seq_pkg::profile_cfg_t live_cfg;
   servo_seq_pkg::seq_status_t status;
   logic s_ok;
   logic error;
   logic alarm_rise;
   logic stalled;
   logic engaged;
   logic step_accept;
   logic cmd_accept;
   logic cmd_reject;
   logic t1_end;
   logic [31:0] cfg_word;
   logic [31:0] brk_word;
   logic [`IRQ_W-1:0] irq_event;

   assign live_cfg = '{s_time_ms: s_time_r, accel_ms: accel_r, block_type: block_type_r,
                       enc_17bit: enc17_r};

   s_curve_range_check u_range (
      .cfg(live_cfg),
      .s_curve_ok(s_ok)
   );

   // ---------------- AXI4-Lite slave ----------------
   assign awready = !aw_hold_r && !bvalid;
   assign wready = !w_hold_r && !bvalid;
   assign arready = !rvalid;
   assign wr_fire = aw_hold_r && w_hold_r && !bvalid;
   assign cfg_word = {16'h0000, brk_seq_r, 3'b000, enc17_r, block_type_r};
   assign brk_word = {stall_time_r, brk_run_r};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_r <= 1'b0;
         w_hold_r <= 1'b0;
         aw_addr_r <= 8'h00;
         w_data_r <= 32'h0000_0000;
         w_strb_r <= 4'h0;
      end else begin
         if (awvalid && awready) begin
            aw_hold_r <= 1'b1;
            aw_addr_r <= awaddr;
         end
         if (wvalid && wready) begin
            w_hold_r <= 1'b1;
            w_data_r <= wdata;
            w_strb_r <= wstrb;
         end
         if (wr_fire) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp <= 2'b00;
      end else if (wr_fire) begin
         bvalid <= 1'b1;
         bresp <= reg_mapped(aw_addr_r) ? 2'b00 : 2'b10;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_time_r <= `S_TIME_RST;
         accel_r <= `ACCEL_RST;
         block_type_r <= 8'(`CFG_RST >> `CFG_BLOCK_LSB);
         enc17_r <= 1'(`CFG_RST >> `CFG_ENC17_BIT);
         brk_seq_r <= 4'(`CFG_RST >> `CFG_BRKSEQ_LSB);
         brk_run_r <= 16'(`BRK_TIME_RST);
         stall_time_r <= 16'(`BRK_TIME_RST >> `BRK_STALL_LSB);
         irq_mask_r <= `IRQ_MASK_RST;
      end else if (wr_fire) begin
         case (aw_addr_r)
            `REG_S_TIME: s_time_r <= 16'(apply_strb({16'h0000, s_time_r}, w_data_r, w_strb_r));
            `REG_ACCEL: accel_r <= 16'(apply_strb({16'h0000, accel_r}, w_data_r, w_strb_r));
            `REG_CFG: begin
               block_type_r <= 8'(apply_strb(cfg_word, w_data_r, w_strb_r) >> `CFG_BLOCK_LSB);
               enc17_r <= 1'(apply_strb(cfg_word, w_data_r, w_strb_r) >> `CFG_ENC17_BIT);
               brk_seq_r <= 4'(apply_strb(cfg_word, w_data_r, w_strb_r) >> `CFG_BRKSEQ_LSB);
            end
            `REG_BRK_TIME: begin
               brk_run_r <= 16'(apply_strb(brk_word, w_data_r, w_strb_r));
               stall_time_r <= 16'(apply_strb(brk_word, w_data_r, w_strb_r) >> `BRK_STALL_LSB);
            end
            `REG_IRQ_MASK: if (w_strb_r[0]) irq_mask_r <= w_data_r[`IRQ_W-1:0];
            default: ;
         endcase
      end
   end

   assign status = '{s_setting_ok: s_ok, servo_engaged: engaged, homing_done: homing_done,
                     s_curve_active: active_s_curve, t1_active: t1_active, alarm: alarm_r,
                     protect_active: protect_r, init_done: init_done_r};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= 2'b00;
      end else if (arvalid && arready) begin
         rvalid <= 1'b1;
         rresp <= reg_mapped(araddr) ? 2'b00 : 2'b10;
         case (araddr)
            `REG_S_TIME: rdata <= {16'h0000, s_time_r};
            `REG_ACCEL: rdata <= {16'h0000, accel_r};
            `REG_CFG: rdata <= cfg_word;
            `REG_BRK_TIME: rdata <= brk_word;
            `REG_STATUS: rdata <= {24'h00_0000, status};
            `REG_IRQ_STATUS: rdata <= {28'h000_0000, irq_stat_r};
            `REG_IRQ_MASK: rdata <= {28'h000_0000, irq_mask_r};
            default: rdata <= 32'h0000_0000;
         endcase
      end else if (rready) begin
         rvalid <= 1'b0;
      end
   end

   // ---------------- interrupts ----------------
   // events are one-cycle pulses, except cmd_reject, which lasts while a start input is held; the status bits hold them
   assign irq_event = (`IRQ_W'(alarm_rise) << `IRQ_ALARM) |
                      (`IRQ_W'(t1_end) << `IRQ_T1_END) |
                      (`IRQ_W'(cmd_reject) << `IRQ_REJECT) |
                      (`IRQ_W'(ms_tick && ms_since_r == 16'(INIT_MS - 1)) << `IRQ_READY);

   // a new event wins over a simultaneous write-one-to-clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_stat_r <= '0;
      end else if (wr_fire && aw_addr_r == `REG_IRQ_STATUS && w_strb_r[0]) begin
         irq_stat_r <= (irq_stat_r & ~w_data_r[`IRQ_W-1:0]) | irq_event;
      end else begin
         irq_stat_r <= irq_stat_r | irq_event;
      end
   end

   assign irq = |(irq_stat_r & irq_mask_r);

   // ---------------- power-on timing ----------------
   assign ms_tick = (ms_cnt_r == MSW'(MS_CYCLES - 1));

   always_ff @(posedge aclk) begin
      if (!aresetn || ms_tick) ms_cnt_r <= '0;
      else ms_cnt_r <= ms_cnt_r + MSW'(1);
   end

   // saturates at the protection point, so the ready interrupt decode cannot match it again
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ms_since_r <= 16'h0000;
         init_done_r <= 1'b0;
         protect_r <= 1'b0;
      end else if (ms_tick && !protect_r) begin
         ms_since_r <= ms_since_r + 16'h0001;
         if (ms_since_r == 16'(INIT_MS - 1)) init_done_r <= 1'b1;
         if (ms_since_r == 16'(PROTECT_MS - 1)) protect_r <= 1'b1; // R9
      end
   end

   // ---------------- alarm and readiness ----------------
   assign error = fault_input || (protect_r && emergency_stop_input); // R9
   assign alarm_rise = error && !alarm_r;
   assign stalled = motor_speed_rpm < `STALL_RPM;

   always_ff @(posedge aclk) begin
      if (!aresetn) alarm_r <= 1'b0;
      else if (error) alarm_r <= 1'b1;
      else if (alarm_clear_input && brk_r == servo_seq_pkg::BRK_HOLD) alarm_r <= 1'b0;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         servo_alarm_output <= 1'b0;
         cw_drive_inhibit <= 1'b0;
         ccw_drive_inhibit <= 1'b0;
      end else begin
         servo_alarm_output <= init_done_r && !alarm_r && !error; // R7
         // inhibits are ignored until protection is armed
         cw_drive_inhibit <= protect_r && cw_overtravel_inhibit; // R9
         ccw_drive_inhibit <= protect_r && ccw_overtravel_inhibit; // R9
      end
   end

   // servo-on may be high during init; commands stay refused until init ends
   assign engaged = servo_on_input && init_done_r && !alarm_r && !error &&
                    brk_r == servo_seq_pkg::BRK_IDLE; // R6
   assign cmd_accept = (step_start_input || homing_start_input) && engaged && !step_busy_r;
   assign step_accept = cmd_accept && step_start_input;
   assign cmd_reject = (step_start_input || homing_start_input) && !init_done_r; // R6

   // ---------------- moves and profile capture ----------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         active_s_curve <= 1'b0;
         active_s_time_ms <= 16'h0000;
         active_accel_ms <= `ACCEL_RST;
      end else if (cmd_accept) begin
         // captured once per move so later writes wait for the next move
         active_s_curve <= s_ok; // R1 R2 R3 R4
         active_s_time_ms <= s_ok ? s_time_r : 16'h0000; // R1
         active_accel_ms <= accel_r; // R1
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         step_busy_r <= 1'b0;
         homing_move_r <= 1'b0;
         homing_done <= 1'b0;
         current_position_outputs <= '0;
      end else if (error) begin
         step_busy_r <= 1'b0;
         homing_move_r <= 1'b0;
         homing_done <= 1'b0; // R13
         current_position_outputs <= '0; // R13
      end else if (cmd_accept) begin
         step_busy_r <= 1'b1;
         homing_move_r <= homing_start_input && !step_start_input;
      end else if (move_done_input && step_busy_r) begin
         step_busy_r <= 1'b0;
         if (homing_move_r) homing_done <= 1'b1;
         else current_position_outputs <= done_point_input;
      end
   end

   assign move_busy = step_busy_r;

   // ---------------- alarm braking interval ----------------
   assign t1_end = brk_r == servo_seq_pkg::BRK_RUN && (stalled || t1_cnt_r >= brk_run_r);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         brk_r <= servo_seq_pkg::BRK_IDLE;
         t1_cnt_r <= 16'h0000;
      end else begin
         case (brk_r)
            servo_seq_pkg::BRK_IDLE: begin
               t1_cnt_r <= 16'h0000;
               if (alarm_rise) begin
                  if (servo_on_input && init_done_r && !stalled) brk_r <= servo_seq_pkg::BRK_RUN;
                  else brk_r <= servo_seq_pkg::BRK_HOLD; // R12
               end
            end
            servo_seq_pkg::BRK_RUN: begin
               if (t1_end) brk_r <= servo_seq_pkg::BRK_HOLD; // R11
               else if (ms_tick) t1_cnt_r <= t1_cnt_r + 16'h0001;
            end
            servo_seq_pkg::BRK_HOLD: begin
               if (!alarm_r) brk_r <= servo_seq_pkg::BRK_IDLE;
            end
            default: brk_r <= servo_seq_pkg::BRK_HOLD;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         motor_drive_on <= 1'b0;
         t1_active <= 1'b0;
      end else begin
         motor_drive_on <= engaged || brk_r == servo_seq_pkg::BRK_RUN;
         t1_active <= brk_r == servo_seq_pkg::BRK_RUN && !t1_end;
      end
   end

   assign alarm_sequence_param = brk_seq_r;
   assign stall_brake_time_param = stall_time_r;

   // ---------------- assertions ----------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   profile_hold_a: assert property (step_busy_r |=> $stable(active_s_curve)) // R1
      else $error("profile changed during a move");
   block_linear_a: assert property (cmd_accept && block_type_r == 8'h01 |=> !active_s_curve) // R2
      else $error("combined block ran S-shaped");
   zero_linear_a: assert property (cmd_accept && s_time_r == 16'h0000 |=> !active_s_curve) // R3
      else $error("zero S time ran S-shaped");
   range_low_a: assert property (cmd_accept && !enc17_r && block_type_r == 8'h00 && // R5
                                 accel_r == 16'h03E8 && s_time_r == 16'h007E |=> active_s_curve)
      else $error("in-range S time refused");
   range_high_a: assert property (cmd_accept && !enc17_r && accel_r == 16'h03E8 && // R4
                                  s_time_r == 16'h007F |=> !active_s_curve)
      else $error("out-of-range S time accepted");
   reject_init_a: assert property (!init_done_r && step_start_input && !step_busy_r // R6
                                   |=> !step_busy_r ##1 irq_stat_r[`IRQ_REJECT])
      else $error("command taken during init");
   ready_out_a: assert property (error |=> !servo_alarm_output [*2]) // R7
      else $error("ready shown with error");
   protect_gate_a: assert property (!protect_r && emergency_stop_input && !fault_input && // R9
                                    !alarm_r |=> !alarm_r)
      else $error("stop acted on before protection");
   t1_end_a: assert property (brk_r == servo_seq_pkg::BRK_RUN && stalled // R11
                              |=> brk_r == servo_seq_pkg::BRK_HOLD && !t1_active)
      else $error("t1 not ended at low speed");
   stall_zero_a: assert property (brk_r == servo_seq_pkg::BRK_IDLE && alarm_rise && stalled // R12
                                  |=> brk_r == servo_seq_pkg::BRK_HOLD ##1 !motor_drive_on)
      else $error("t1 not zero when stalled");
   alarm_pos_a: assert property (error |=> current_position_outputs == '0 && !homing_done) // R13
      else $error("position not cleared on alarm");

   s_move_c: cover property (cmd_accept ##1 active_s_curve);
   t1_timeout_c: cover property (brk_r == servo_seq_pkg::BRK_RUN && !stalled && t1_end);
   reject_c: cover property (cmd_reject);
   irq_c: cover property ($rose(irq));
endmodule // servo_profile_and_alarm_sequencer

// >>> test/host_model.sv
// host controller model driving the discrete command inputs
module host_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic servo_alarm_output,
   input wire logic want_on,
   output logic servo_on_input,
   output logic cw_overtravel_inhibit,
   output logic ccw_overtravel_inhibit,
   output logic emergency_stop_input
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] settle_r;
   // protective levels fixed from power-on, well before protection arms
   initial begin
      cw_overtravel_inhibit = 1'b1;
      ccw_overtravel_inhibit = 1'b1;
      emergency_stop_input = 1'b0;
   end
   // main power needs a few cycles to settle after ready
   always @(posedge aclk) begin
      if (!aresetn || !servo_alarm_output) begin
         settle_r <= 4'h0;
      end else if (settle_r != 4'hF) begin
         settle_r <= settle_r + 4'h1;
      end
      servo_on_input <= want_on && (settle_r > 4'h3) | (servo_on_input && want_on);
   end
endmodule // host_model

// >>> test/tb.sv
// self-checking testbench of the servo profile and alarm sequencer
`include "servo_seq_regs.svh"
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
   logic arready, rvalid, fault_input, alarm_clear_input, step_start_input, homing_start_input;
   logic move_done_input, servo_alarm_output, motor_drive_on, t1_active, cw_drive_inhibit;
   logic ccw_drive_inhibit, move_busy, active_s_curve, homing_done, irq, want_on;
   logic servo_on_input, cw_overtravel_inhibit, ccw_overtravel_inhibit, emergency_stop_input;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [3:0] wstrb, alarm_sequence_param;
   logic [1:0] bresp, rresp, rs;
   logic [15:0] motor_speed_rpm, active_s_time_ms, active_accel_ms, stall_brake_time_param;
   logic [5:0] done_point_input, current_position_outputs;
   int err_total, check_count, cyc, n;
   servo_profile_and_alarm_sequencer #(.MS_CYCLES(4), .INIT_MS(3), .PROTECT_MS(6), .POS_W(6))
   u_servo_profile_and_alarm_sequencer (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
      .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
      .rresp, .rvalid, .rready, .servo_on_input, .cw_overtravel_inhibit, .ccw_overtravel_inhibit,
      .emergency_stop_input, .fault_input, .alarm_clear_input, .motor_speed_rpm,
      .step_start_input, .homing_start_input, .move_done_input, .done_point_input,
      .servo_alarm_output, .motor_drive_on, .t1_active, .cw_drive_inhibit, .ccw_drive_inhibit,
      .move_busy, .active_s_curve, .active_s_time_ms, .active_accel_ms, .homing_done,
      .current_position_outputs, .alarm_sequence_param, .stall_brake_time_param, .irq);
   host_model u_host_model (.aclk, .aresetn, .servo_alarm_output, .want_on, .servo_on_input,
      .cw_overtravel_inhibit, .ccw_overtravel_inhibit, .emergency_stop_input);
   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total = err_total + 1;
         stop_test();
      end
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count = check_count + 1;
      if (g !== e) begin
         err_total = err_total + 1;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // readies are combinational, so they are sampled mid-cycle where they are settled
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      logic ad, wd, bd;
      ad = 0;
      wd = 0;
      @(posedge aclk);
      awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
      do begin
         @(negedge aclk);
         ad = ad | (awvalid & awready);
         wd = wd | (wvalid & wready);
         bd = bvalid;
         rs = bresp;
         @(posedge aclk);
         if (ad) awvalid <= 0;
         if (wd) wvalid <= 0;
      end while (!bd);
      bready <= 0;
   endtask
   task automatic axi_rd(input logic [7:0] a);
      logic ad, rv;
      ad = 0;
      @(posedge aclk);
      araddr <= a; arvalid <= 1; rready <= 1;
      do begin
         @(negedge aclk);
         ad = ad | (arvalid & arready);
         rv = rvalid;
         rd = rdata;
         rs = rresp;
         @(posedge aclk);
         if (ad) arvalid <= 0;
      end while (!rv);
      rready <= 0;
   endtask
   task automatic wait_hi(ref logic s, input int lim);
      n = 0;
      while (s !== 1'b1 && n < lim) begin
         @(posedge aclk);
         n = n + 1;
      end
      #1;
   endtask
   // one step move; optionally rewrites the S time while it runs
   task automatic do_move(input logic [5:0] pt, input logic es, input logic [15:0] et,
                          input logic mid);
      @(posedge aclk) step_start_input <= 1;
      @(posedge aclk) step_start_input <= 0;
      wait_hi(move_busy, 4);
      chk("busy", 1, move_busy);
      chk("s_curve", es, active_s_curve);
      chk("s_time", et, active_s_time_ms);
      if (mid) begin
         axi_wr(`REG_S_TIME, 32'h0000_0000);
         chk("s_curve_mid", es, active_s_curve);
      end
      @(posedge aclk) begin done_point_input <= pt; move_done_input <= 1; end
      @(posedge aclk) move_done_input <= 0;
      repeat (2) @(posedge aclk);
      chk("busy_end", 0, move_busy);
      chk("position", pt, current_position_outputs);
   endtask
   task automatic set_prof(input logic [31:0] cfg, input logic [15:0] s);
      axi_wr(`REG_CFG, cfg);
      axi_wr(`REG_S_TIME, {16'h0000, s});
   endtask
   task automatic raise_fault(input logic [15:0] spd);
      @(posedge aclk) begin motor_speed_rpm <= spd; fault_input <= 1; end
      repeat (3) @(posedge aclk);
      #1;
      chk("pos_alarm", 0, current_position_outputs);
      chk("homing_alarm", 0, homing_done);
      chk("ready_alarm", 0, servo_alarm_output);
   endtask
   task automatic clear_alarm();
      @(posedge aclk) begin fault_input <= 0; motor_speed_rpm <= 16'h0000; end
      repeat (40) @(posedge aclk);
      alarm_clear_input <= 1;
      @(posedge aclk) alarm_clear_input <= 0;
      wait_hi(servo_alarm_output, 40);
      chk("ready_again", 1, servo_alarm_output);
      wait_hi(servo_on_input, 20);
   endtask
   initial begin
      err_total = 0; check_count = 0; cyc = 0; aresetn = 0; awaddr = 0; araddr = 0;
      awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0; wdata = 0;
      wstrb = 4'hF; fault_input = 0; alarm_clear_input = 0; step_start_input = 0;
      homing_start_input = 0; move_done_input = 0; done_point_input = 0;
      motor_speed_rpm = 0; want_on = 0;
      repeat (12) @(posedge aclk);
      aresetn <= 1;
      #1;
      chk("ready_rst", 0, servo_alarm_output);
      chk("accel_rst", 16'h0064, active_accel_ms);
      @(posedge aclk) step_start_input <= 1;
      @(posedge aclk) step_start_input <= 0;
      repeat (3) @(posedge aclk);
      chk("busy_init", 0, move_busy);
      chk("cw_early", 0, cw_drive_inhibit);
      axi_rd(`REG_IRQ_STATUS);
      chk("irq_reject", 1, rd[`IRQ_REJECT]);
      axi_rd(8'h40);
      chk("unmapped", 2'b10, rs);
      wait_hi(servo_alarm_output, 40);
      chk("ready_init", 1, servo_alarm_output);
      repeat (30) @(posedge aclk);
      chk("cw_armed", 1, cw_drive_inhibit);
      chk("ccw_armed", 1, ccw_drive_inhibit);
      want_on <= 1;
      wait_hi(servo_on_input, 20);
      axi_wr(`REG_ACCEL, 32'h0000_03E8);
      set_prof(32'h0000_0000, 16'd126);
      do_move(6'h05, 1, 16'd126, 1);
      do_move(6'h06, 0, 16'd0, 0);
      set_prof(32'h0000_0000, 16'd127);
      do_move(6'h07, 0, 16'd0, 0);
      set_prof(32'h0000_0001, 16'd126);
      do_move(6'h08, 0, 16'd0, 0);
      set_prof(32'h0000_3100, 16'd1676);
      chk("seq_par", 3, alarm_sequence_param);
      do_move(6'h09, 1, 16'd1676, 0);
      set_prof(32'h0000_0100, 16'd1677);
      do_move(6'h0A, 0, 16'd0, 0);
      axi_wr(`REG_IRQ_STATUS, 32'h0000_000F);
      axi_wr(`REG_IRQ_MASK, 32'h0000_0001);
      axi_wr(`REG_BRK_TIME, 32'h0005_0064);
      chk("stall_par", 5, stall_brake_time_param);
      raise_fault(16'd1000);
      chk("t1_run", 1, t1_active);
      chk("drive_t1", 1, motor_drive_on);
      chk("irq_on", 1, irq);
      @(posedge aclk) motor_speed_rpm <= 16'd29;
      repeat (4) @(posedge aclk);
      chk("t1_speed", 0, t1_active);
      clear_alarm();
      axi_wr(`REG_IRQ_STATUS, 32'h0000_000F);
      chk("irq_off", 0, irq);
      axi_wr(`REG_BRK_TIME, 32'h0000_0002);
      do_move(6'h0B, 0, 16'd0, 0);
      raise_fault(16'd1000);
      n = 0;
      while (t1_active === 1'b1 && n < 40) begin
         @(posedge aclk);
         n = n + 1;
      end
      chk("t1_timer", 1, (n >= 3 && n <= 16));
      clear_alarm();
      axi_wr(`REG_IRQ_STATUS, 32'h0000_000F);
      raise_fault(16'd0);
      repeat (6) @(posedge aclk);
      axi_rd(`REG_IRQ_STATUS);
      chk("t1_stall", 0, rd[`IRQ_T1_END]);
      stop_test();
   end
endmodule // tb
